// [inc/exc_pkg.sv]
// constants, field layouts and carriers shared by the exception and status logic
package exc_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ------------------------------------------------------------------
  localparam int APB_ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RESUME = 8'h04;
  localparam logic [7:0] ADDR_PENDING = 8'h08;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [31:0] STATUS_RESET = 32'h0040_0000;
  localparam logic [31:0] RESUME_RESET = 32'h0000_0000;
  localparam logic [1:0] SW_IRQ_RESET = 2'h0;

  // ------------------------------------------------------------------
  // write masks and field positions
  // ------------------------------------------------------------------
  localparam logic [31:0] STATUS_WR_MASK = 32'hf047_ff3f;
  localparam logic [31:0] STATUS_W1C_MASK = 32'h0010_0000;
  localparam int PEND_SW_LSB = 8;
  localparam int PEND_HW_LSB = 10;
  localparam int HW_IRQ_N = 6;

  // ------------------------------------------------------------------
  // encodings and bootstrap vectors
  // ------------------------------------------------------------------
  localparam logic PRIV_KERNEL = 1'b0;
  localparam logic PRIV_USER = 1'b1;
  localparam logic IRQ_OFF = 1'b0;
  localparam logic [31:0] BOOT_USER_TLB_MISS_VEC = 32'hbfc0_0100;
  localparam logic [31:0] BOOT_GEN_VEC = 32'hbfc0_0180;

  // status register layout, msb first
  typedef struct packed {
    logic [3:0] coproc_usable_mask;
    logic [4:0] diag_zero;
    logic boot_vector_select;
    logic tlb_shutdown_flag;
    logic parity_err_flag;
    logic isolated_miss_flag;
    logic parity_zero_bit;
    logic cache_swap_bit;
    logic cache_isolate_bit;
    logic [7:0] irq_mask_field;
    logic [1:0] low_zero;
    logic old_priv_mode;
    logic irq_en_old;
    logic prev_priv_mode;
    logic irq_en_prev;
    logic current_priv_mode;
    logic irq_en_cur;
  } status_t;

  // one data reference from the load/store unit
  typedef struct packed {
    logic valid;
    logic write;
    logic uncached;
  } data_ref_t;

  // gating of a data reference by cache isolation
  typedef struct packed {
    logic mem_wr_inhibit;
    logic mem_rd_inhibit;
    logic cache_wr_block;
    logic cache_read_force;
  } data_gate_t;

endpackage : exc_pkg

// [src/exception_status_control.sv]
// exception resume address, processor status and diagnostic control
`timescale 1ns/100ps
module exception_status_control #(
  parameter logic [31:0] NORM_USER_TLB_MISS_VEC = 32'h0000_0000,
  parameter logic [31:0] NORM_GEN_VEC = 32'h0000_0080,
  parameter int CACHE_CTL_W = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [exc_pkg::APB_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // exception events from the pipeline
  input wire logic i_exc_take,
  input wire logic [31:0] i_exc_pc,
  input wire logic i_exc_in_delay_slot,
  input wire logic [31:0] i_exc_branch_pc,
  input wire logic i_exc_return,
  // interrupt sources and request
  input wire logic [exc_pkg::HW_IRQ_N-1:0] i_hw_irq,
  output logic o_irq_req,
  // mode and coprocessor usability
  output logic o_kernel_mode,
  output logic [3:0] o_cop_usable,
  // exception vectors
  output logic [31:0] o_user_tlb_miss_vector,
  output logic [31:0] o_gen_vector,
  // cache control routing
  input wire logic [CACHE_CTL_W-1:0] i_icache_ctl,
  input wire logic [CACHE_CTL_W-1:0] i_dcache_ctl,
  output logic [CACHE_CTL_W-1:0] o_cache0_ctl,
  output logic [CACHE_CTL_W-1:0] o_cache1_ctl,
  output logic o_cache_swapped,
  // data reference gating and cache diagnostics
  input wire exc_pkg::data_ref_t i_data_ref,
  output exc_pkg::data_gate_t o_data_gate,
  input wire logic i_dload_done,
  input wire logic i_dload_miss,
  input wire logic i_parity_err,
  output logic o_parity_zero,
  // tlb protection
  input wire logic i_tlb_multi_hit,
  output logic o_tlb_inhibit
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    exc_pkg::status_t status;
    logic [31:0] resume;
    logic [1:0] sw_ip;
    logic [exc_pkg::HW_IRQ_N-1:0] hw_ip;
    logic [exc_pkg::HW_IRQ_N-1:0] sync1;
    logic [exc_pkg::HW_IRQ_N-1:0] sync2;
    logic [exc_pkg::HW_IRQ_N-1:0] sync3;
    logic [31:0] rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ------------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------------
  // expand byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_mask

  // true for an address that maps to a register
  function automatic logic addr_hit(input logic [exc_pkg::APB_ADDR_W-1:0] a);
    return (a == exc_pkg::ADDR_STATUS) || (a == exc_pkg::ADDR_RESUME) ||
           (a == exc_pkg::ADDR_PENDING);
  endfunction : addr_hit

  // software write into the status word; hardware-owned bits keep their value
  function automatic logic [31:0] status_write(input logic [31:0] cur,
                                               input logic [31:0] wd,
                                               input logic [31:0] wm);
    logic [31:0] m;
    logic [31:0] v;
    // only defined bits take writes; unused diagnostic bits stay zero
    m = wm & exc_pkg::STATUS_WR_MASK;
    v = (cur & ~m) | (wd & m);
    // writing one clears the parity error, zero leaves it
    if ((wd & wm & exc_pkg::STATUS_W1C_MASK) != 32'h0000_0000) begin
      v = v & ~exc_pkg::STATUS_W1C_MASK;
    end
    return v;
  endfunction : status_write

  // register read mux; unmapped addresses read zero
  function automatic logic [31:0] read_word(input logic [exc_pkg::APB_ADDR_W-1:0] a,
                                            input logic [31:0] stat,
                                            input logic [31:0] res,
                                            input logic [7:0] pend);
    logic [31:0] v;
    case (a)
      exc_pkg::ADDR_STATUS: v = stat;
      exc_pkg::ADDR_RESUME: v = res;
      exc_pkg::ADDR_PENDING: v = {16'h0000, pend, 8'h00};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_word

  // push the mode/enable stack: current to previous, previous to old
  function automatic exc_pkg::status_t stack_push(input exc_pkg::status_t s);
    exc_pkg::status_t r;
    // every other field passes through untouched
    r = s;
    r.old_priv_mode = s.prev_priv_mode;
    r.irq_en_old = s.irq_en_prev;
    r.prev_priv_mode = s.current_priv_mode;
    r.irq_en_prev = s.irq_en_cur;
    r.current_priv_mode = exc_pkg::PRIV_KERNEL;
    r.irq_en_cur = exc_pkg::IRQ_OFF;
    return r;
  endfunction : stack_push

  // pop the stack: previous to current, old to previous, old stays
  function automatic exc_pkg::status_t stack_pop(input exc_pkg::status_t s);
    exc_pkg::status_t r;
    r = s;
    r.current_priv_mode = s.prev_priv_mode;
    r.irq_en_cur = s.irq_en_prev;
    r.prev_priv_mode = s.old_priv_mode;
    r.irq_en_prev = s.irq_en_old;
    return r;
  endfunction : stack_pop

  // isolation gating of one data reference; fetches never come through here
  function automatic exc_pkg::data_gate_t gate_ref(input logic iso,
                                                   input exc_pkg::data_ref_t r);
    exc_pkg::data_gate_t g;
    g = '0;
    if (iso && r.valid) begin
      g.mem_wr_inhibit = r.write;
      g.mem_rd_inhibit = !r.write;
      g.cache_wr_block = r.write && r.uncached;
      g.cache_read_force = !r.write;
    end
    return g;
  endfunction : gate_ref

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic setup_ph;
  logic wr_en;
  logic [31:0] wmask;
  logic [7:0] pending;

  // setup phase samples read data, access phase commits writes
  assign setup_ph = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite && addr_hit(i_paddr);
  assign wmask = strb_mask(i_pstrb);
  assign pending = {st_q.hw_ip, st_q.sw_ip};

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [31:0] sv;
    sv = 32'h0000_0000;
    st_d = st_q;

    // three-stage sampling; a change counts once stages two and three agree
    st_d.sync1 = i_hw_irq;
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int b = 0; b < exc_pkg::HW_IRQ_N; b++) begin
      // each pin settles on its own; a bouncing pin does not hold the others
      if (st_q.sync2[b] == st_q.sync3[b]) begin
        st_d.hw_ip[b] = st_q.sync3[b];
      end
    end

    // read data is captured in the setup cycle
    if (setup_ph) begin
      st_d.rdata = read_word(i_paddr, st_q.status, st_q.resume, pending);
    end

    // software writes; resume address ignores them
    if (wr_en) begin
      case (i_paddr)
        exc_pkg::ADDR_STATUS: begin
          // only defined bits take writes; ts and cm stay hardware owned
          sv = status_write(st_q.status, i_pwdata, wmask);
          st_d.status = exc_pkg::status_t'(sv);
        end
        exc_pkg::ADDR_PENDING: begin
          if (wmask[exc_pkg::PEND_SW_LSB]) begin
            st_d.sw_ip = i_pwdata[exc_pkg::PEND_SW_LSB +: 2];
          end
        end
        default: begin
          st_d.sw_ip = st_d.sw_ip;
        end
      endcase
    end

    // exception entry pushes the status after a software write in the same cycle
    if (i_exc_take) begin
      // delay-slot faults restart at the branch, others at the fault itself
      if (i_exc_in_delay_slot) begin
        st_d.resume = i_exc_branch_pc;
      end else begin
        st_d.resume = i_exc_pc;
      end
      // push: current moves to previous, previous to old
      st_d.status = stack_push(st_d.status);
    end else if (i_exc_return) begin
      // pop: old stays, and also fills previous
      st_d.status = stack_pop(st_d.status);
    end

    // parity error set wins over a clear in the same cycle
    if (i_parity_err) begin
      st_d.status.parity_err_flag = 1'b1;
    end

    // tlb shutdown is sticky until reset
    if (i_tlb_multi_hit) begin
      st_d.status.tlb_shutdown_flag = 1'b1;
    end

    // miss flag follows data cache loads while isolated
    if (st_q.status.cache_isolate_bit && i_dload_done) begin
      st_d.status.isolated_miss_flag = i_dload_miss;
    end

    // unused diagnostic and low bits always hold zero
    st_d.status.diag_zero = 5'h00;
    st_d.status.low_zero = 2'h0;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q.status <= exc_pkg::status_t'(exc_pkg::STATUS_RESET);
      st_q.resume <= exc_pkg::RESUME_RESET;
      st_q.sw_ip <= exc_pkg::SW_IRQ_RESET;
      st_q.hw_ip <= '0;
      st_q.sync1 <= '0;
      st_q.sync2 <= '0;
      st_q.sync3 <= '0;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------------
  // zero wait states; unmapped addresses answer with an error
  assign o_prdata = st_q.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit(i_paddr);

  // ------------------------------------------------------------------
  // mode, interrupt and vectors
  // ------------------------------------------------------------------
  // kernel when the current mode bit is zero
  assign o_kernel_mode = (st_q.status.current_priv_mode == exc_pkg::PRIV_KERNEL);

  // coprocessor zero forced usable in kernel mode
  assign o_cop_usable = st_q.status.coproc_usable_mask |
                        {3'h0, o_kernel_mode};

  // interrupt needs the enable and a matching mask and pending bit
  assign o_irq_req = st_q.status.irq_en_cur &&
                     ((st_q.status.irq_mask_field & pending) != 8'h00);

  // bootstrap vectors when the boot bit is set
  assign o_user_tlb_miss_vector = st_q.status.boot_vector_select ?
                         exc_pkg::BOOT_USER_TLB_MISS_VEC : NORM_USER_TLB_MISS_VEC;
  assign o_gen_vector = st_q.status.boot_vector_select ?
                        exc_pkg::BOOT_GEN_VEC : NORM_GEN_VEC;

  // ------------------------------------------------------------------
  // cache routing and isolation
  // ------------------------------------------------------------------
  // swapped caches trade control signals; software keeps the switch quiet
  assign o_cache_swapped = st_q.status.cache_swap_bit;
  for (genvar b = 0; b < CACHE_CTL_W; b++) begin : g_route
    // each control line crosses over bit for bit
    assign o_cache0_ctl[b] = st_q.status.cache_swap_bit ?
                             i_dcache_ctl[b] : i_icache_ctl[b];
    assign o_cache1_ctl[b] = st_q.status.cache_swap_bit ?
                             i_icache_ctl[b] : i_dcache_ctl[b];
  end

  // isolation gates data references only; fetches have no path here
  assign o_data_gate = gate_ref(st_q.status.cache_isolate_bit, i_data_ref);

  // ------------------------------------------------------------------
  // parity and tlb controls
  // ------------------------------------------------------------------
  assign o_parity_zero = st_q.status.parity_zero_bit;
  assign o_tlb_inhibit = st_q.status.tlb_shutdown_flag;

endmodule : exception_status_control

// [test/exception_status_control_checker.sv]
// assertion checker for the exception and status block
`timescale 1ns/100ps
module exc_status_checker #(
  parameter logic [31:0] NORM_USER_TLB_MISS_VEC = 32'h0000_0000,
  parameter logic [31:0] NORM_GEN_VEC = 32'h0000_0080,
  parameter int CACHE_CTL_W = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // watched ports
  input wire logic i_exc_take,
  input wire logic o_kernel_mode,
  input wire logic o_irq_req,
  input wire logic [3:0] o_cop_usable,
  input wire logic [CACHE_CTL_W-1:0] i_icache_ctl,
  input wire logic [CACHE_CTL_W-1:0] i_dcache_ctl,
  input wire logic [CACHE_CTL_W-1:0] o_cache0_ctl,
  input wire logic [CACHE_CTL_W-1:0] o_cache1_ctl,
  input wire logic o_cache_swapped,
  input wire exc_pkg::data_ref_t i_data_ref,
  input wire exc_pkg::data_gate_t o_data_gate,
  input wire logic i_tlb_multi_hit,
  input wire logic o_tlb_inhibit,
  input wire logic [31:0] o_user_tlb_miss_vector,
  input wire logic [31:0] o_gen_vector
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  push_to_kernel_a:
  assert property (i_exc_take |=> o_kernel_mode && !o_irq_req)
    else $error("exception left user mode or interrupt request");
  cop0_kernel_a:
  assert property (o_kernel_mode |-> o_cop_usable[0])
    else $error("coprocessor zero unusable in kernel mode");
  swap_on_a:
  assert property (o_cache_swapped |->
    o_cache0_ctl == i_dcache_ctl && o_cache1_ctl == i_icache_ctl)
    else $error("swapped cache routing wrong");
  swap_off_a:
  assert property (!o_cache_swapped |->
    o_cache0_ctl == i_icache_ctl && o_cache1_ctl == i_dcache_ctl)
    else $error("normal cache routing wrong");
  store_gate_a:
  assert property (o_data_gate.mem_wr_inhibit |-> i_data_ref.valid && i_data_ref.write
    && !o_data_gate.mem_rd_inhibit && o_data_gate.cache_wr_block == i_data_ref.uncached)
    else $error("isolated store gating wrong");
  load_gate_a:
  assert property (o_data_gate.mem_rd_inhibit |-> i_data_ref.valid && !i_data_ref.write
    && o_data_gate.cache_read_force && !o_data_gate.cache_wr_block)
    else $error("isolated load gating wrong");
  tlb_hold_a:
  assert property (i_tlb_multi_hit || o_tlb_inhibit |=> o_tlb_inhibit)
    else $error("tlb shutdown not set or cleared without reset");
  vector_pair_a:
  assert property ((o_user_tlb_miss_vector == exc_pkg::BOOT_USER_TLB_MISS_VEC
    && o_gen_vector == exc_pkg::BOOT_GEN_VEC)
    || (o_user_tlb_miss_vector == NORM_USER_TLB_MISS_VEC && o_gen_vector == NORM_GEN_VEC))
    else $error("exception vectors inconsistent");
endmodule : exc_status_checker

bind exception_status_control exc_status_checker #(
  .NORM_USER_TLB_MISS_VEC(NORM_USER_TLB_MISS_VEC), .NORM_GEN_VEC(NORM_GEN_VEC), .CACHE_CTL_W(CACHE_CTL_W)
) chk_u (
  .i_ref_clk, .i_rst, .i_exc_take, .o_kernel_mode, .o_irq_req, .o_cop_usable, .i_icache_ctl,
  .i_dcache_ctl, .o_cache0_ctl, .o_cache1_ctl, .o_cache_swapped, .i_data_ref, .o_data_gate,
  .i_tlb_multi_hit, .o_tlb_inhibit, .o_user_tlb_miss_vector, .o_gen_vector
);

// [test/test_exception_status_control.sv]
// self-checking bench for the exception and status block
`timescale 1ns/100ps
module test_exception_status_control;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic i_ref_clk, i_rst, i_psel, i_penable, i_pwrite, i_exc_take, i_exc_in_delay_slot;
  logic i_exc_return, i_dload_done, i_dload_miss, i_parity_err, i_tlb_multi_hit;
  logic [7:0] i_paddr;
  logic [3:0] i_pstrb, i_icache_ctl, i_dcache_ctl, o_cop_usable, o_cache0_ctl, o_cache1_ctl;
  logic [5:0] i_hw_irq;
  logic [31:0] i_pwdata, i_exc_pc, i_exc_branch_pc, o_prdata, o_user_tlb_miss_vector, o_gen_vector, rdata;
  logic o_pready, o_pslverr, o_irq_req, o_kernel_mode, o_cache_swapped, o_parity_zero;
  logic o_tlb_inhibit, serr;
  exc_pkg::data_ref_t i_data_ref;
  exc_pkg::data_gate_t o_data_gate;
  int miscompares = 0;
  int comparisons = 0;

  exception_status_control dut_u (
    .i_ref_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
    .o_prdata, .o_pready, .o_pslverr, .i_exc_take, .i_exc_pc, .i_exc_in_delay_slot,
    .i_exc_branch_pc, .i_exc_return, .i_hw_irq, .o_irq_req, .o_kernel_mode, .o_cop_usable,
    .o_user_tlb_miss_vector, .o_gen_vector, .i_icache_ctl, .i_dcache_ctl, .o_cache0_ctl, .o_cache1_ctl,
    .o_cache_swapped, .i_data_ref, .o_data_gate, .i_dload_done, .i_dload_miss, .i_parity_err,
    .o_parity_zero, .i_tlb_multi_hit, .o_tlb_inhibit
  );

  // 100 mhz clock
  initial begin
    i_ref_clk = 1'h0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'h1;
    @(posedge i_ref_clk);
    while (o_pready !== 1'h1) begin
      n++;
      if (n > 50) begin
        miscompares++;
        wrap_up();
      end
      @(posedge i_ref_clk);
    end
    rdata = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_ref_clk);
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd

  // pulse on take (ret low) or return (ret high)
  task automatic exc(input logic ds, input logic ret);
    i_exc_take <= ~ret;
    i_exc_return <= ret;
    i_exc_in_delay_slot <= ds;
    @(posedge i_ref_clk);
    i_exc_take <= 1'h0;
    i_exc_return <= 1'h0;
    @(posedge i_ref_clk);
  endtask : exc

  // one-cycle pulse on {load done, load miss, parity error, tlb multi hit}
  task automatic ev(input logic [3:0] v);
    {i_dload_done, i_dload_miss, i_parity_err, i_tlb_multi_hit} <= v;
    @(posedge i_ref_clk);
    {i_dload_done, i_dload_miss, i_parity_err, i_tlb_multi_hit} <= 4'h0;
    @(posedge i_ref_clk);
  endtask : ev

  // every data reference kind against the expected gating
  task automatic gates(input logic iso);
    logic [31:0] e;
    for (int k = 0; k < 8; k++) begin
      i_data_ref <= 3'(k);
      @(posedge i_ref_clk);
      e = (iso && k[2]) ? {28'h0, k[1], !k[1], k[1] & k[0], !k[1]} : 32'h0;
      chk(32'(o_data_gate), e);
    end
  endtask : gates

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'h1;
    {i_psel, i_penable, i_pwrite, i_exc_take, i_exc_in_delay_slot, i_exc_return} = 6'h0;
    {i_dload_done, i_dload_miss, i_parity_err, i_tlb_multi_hit} = 4'h0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    i_pstrb = 4'hf;
    i_hw_irq = 6'h00;
    i_icache_ctl = 4'h3;
    i_dcache_ctl = 4'hc;
    i_data_ref = '0;
    i_exc_pc = 32'h1234_5678;
    i_exc_branch_pc = 32'habcd_0000;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    @(posedge i_ref_clk);
    rd(8'h00, 32'h0040_0000);
    chk(o_gen_vector, 32'hbfc0_0180);
    chk(o_user_tlb_miss_vector, exc_pkg::BOOT_USER_TLB_MISS_VEC);
    chk(32'(o_kernel_mode), 32'h1);
    rd(8'h04, 32'h0);
    chk(32'(o_cop_usable), 32'h1);
    xfer(1'h1, 8'h00, 32'hffff_ffff);
    rd(8'h00, 32'hf047_ff3f);
    chk(32'(o_parity_zero), 32'h1);
    chk(32'(o_cache0_ctl), 32'hc);
    chk(32'(o_cache1_ctl), 32'h3);
    chk(32'(o_cache_swapped), 32'h1);
    chk(32'(o_kernel_mode), 32'h0);
    chk(32'(o_irq_req), 32'h0);
    xfer(1'h1, 8'h04, 32'h5555_aaaa);
    rd(8'h04, 32'h0);
    xfer(1'h0, 8'h0c, 32'h0);
    chk(32'(serr), 32'h1);
    xfer(1'h1, 8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0300);
    chk(32'(o_irq_req), 32'h1);
    xfer(1'h1, 8'h00, 32'h0000_fc27);
    chk(32'(o_irq_req), 32'h0);
    chk(o_user_tlb_miss_vector, 32'h0);
    chk(o_gen_vector, 32'h0000_0080);
    chk(32'(o_parity_zero), 32'h0);
    chk(32'(o_cache0_ctl), 32'h3);
    xfer(1'h1, 8'h00, 32'h0000_ff27);
    chk(32'(o_irq_req), 32'h1);
    exc(1'h0, 1'h0);
    rd(8'h04, 32'h1234_5678);
    rd(8'h00, 32'h0000_ff1c);
    exc(1'h1, 1'h0);
    rd(8'h04, 32'habcd_0000);
    rd(8'h00, 32'h0000_ff30);
    exc(1'h0, 1'h1);
    rd(8'h00, 32'h0000_ff3c);
    exc(1'h0, 1'h1);
    rd(8'h00, 32'h0000_ff3f);
    chk(32'(o_irq_req), 32'h1);
    chk(32'(o_cop_usable), 32'h0);
    i_hw_irq <= 6'h21;
    repeat (4) @(posedge i_ref_clk);
    rd(8'h08, 32'h0000_8700);
    i_pstrb <= 4'hd;
    xfer(1'h1, 8'h08, 32'h0);
    i_pstrb <= 4'hf;
    rd(8'h08, 32'h0000_8700);
    xfer(1'h1, 8'h08, 32'h0);
    rd(8'h08, 32'h0000_8400);
    gates(1'h0);
    xfer(1'h1, 8'h00, 32'h0001_0000);
    gates(1'h1);
    ev(4'hc);
    rd(8'h00, 32'h0009_0000);
    ev(4'h8);
    rd(8'h00, 32'h0001_0000);
    ev(4'h2);
    xfer(1'h1, 8'h00, 32'h0001_0000);
    rd(8'h00, 32'h0011_0000);
    xfer(1'h1, 8'h00, 32'h0011_0000);
    rd(8'h00, 32'h0001_0000);
    ev(4'h1);
    chk(32'(o_tlb_inhibit), 32'h1);
    xfer(1'h1, 8'h00, 32'h0);
    rd(8'h00, 32'h0020_0000);
    i_rst <= 1'h1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    @(posedge i_ref_clk);
    chk(32'(o_tlb_inhibit), 32'h0);
    rd(8'h00, 32'h0040_0000);
    wrap_up();
  end
endmodule : test_exception_status_control
